// file: inc/ldm_map.vh
// Function
// - supply below reset level: reset, outputs high impedance, pull-up on
// - rising supply enters init, sets error bit 0, loads defaults
// - init samples configuration; valid goes normal, faulty goes sleep
// - init: transceiver off, outputs high impedance, bounded by init time
// - bus idle past timeout sends normal or undervoltage mode to sleep
// - go-to-sleep command in normal switches drivers off and enters sleep
// - sleep keeps drivers off, waits for wake, keeps error bits
// - dominant bus for wake minimum then recessive moves sleep to init
// - transceiver active only in normal and global shutdown
// - channels four, eight: overtemperature or overcurrent ORed, 01000b
// - overtemperature on four or eight latches driver off and fault bits
// - commanding a latched driver off clears latch, status and fault bit
// - global shutdown forces application fault bit 3 low
// - overcurrent longer than filter delay latches that driver off
// - overcurrent on other channels shows only in channel status
// - global overtemperature: drivers off, transceiver kept, bit 2 set
// - global shutdown ends on cooling; bit 2 is not latched
// - undervoltage: transceiver off, drivers kept, rise level ends it
// - protocol errors use a three-bit error field
// - byte 1 carries error bits and fault field; bytes 4 to 8 zero
// - bytes 2 and 3 carry two-bit channel status, lowest channel lowest
// - output control frame sets all outputs of the node at once
// - re-initialization request applies to the whole virtual node
// - status codes: 00 open load, 01 off, 10 on, 11 latched
// - a response carrying the error field clears it after transmission
// - error codes by priority, highest pending code wins
// - targeted reset turns outputs off and sets error field to 001
`ifndef LDM_MAP_VH
`define LDM_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define LDM_OFS_CTRL 8'h00
`define LDM_OFS_STAT 8'h04
`define LDM_OFS_CHST 8'h08
`define LDM_OFS_RESP 8'h0C
`define LDM_OFS_RESP_HI 8'h10

// ****************************************
// control fields
// ****************************************
`define LDM_CTRL_SLEEP_BIT 8
`define LDM_CTRL_TRST_BIT 9
`define LDM_CMD_RST 8'h00
`define LDM_ERR_RST 3'h1
`define LDM_ERR_NONE 3'h0

// ****************************************
// modes and channel status codes
// ****************************************
`define LDM_M_POR 3'h0
`define LDM_M_INIT 3'h1
`define LDM_M_NORM 3'h2
`define LDM_M_SLEEP 3'h3
`define LDM_M_UV 3'h4
`define LDM_M_GTSD 3'h5
`define LDM_ST_OPEN 2'h0
`define LDM_ST_OFF 2'h1
`define LDM_ST_ON 2'h2
`define LDM_ST_LATCH 2'h3

// ****************************************
// timing
// ****************************************
`define LDM_CLK_MHZ 100
`define LDM_T_INIT_US 100
`define LDM_T_IDLE_MS 4
`define LDM_T_WAKE_US 150
`define LDM_T_OC_US 15
`define LDM_INIT_CYC (`LDM_T_INIT_US * `LDM_CLK_MHZ)
`define LDM_IDLE_CYC (`LDM_T_IDLE_MS * 1000 * `LDM_CLK_MHZ)
`define LDM_WAKE_CYC (`LDM_T_WAKE_US * `LDM_CLK_MHZ)
`define LDM_OC_CYC (`LDM_T_OC_US * `LDM_CLK_MHZ)

`endif

// file: logic/ldm_chan.v
`timescale 1ns/10ps
`include "ldm_map.vh"
module ldm_chan #(
  parameter [31:0] OC_CYC = `LDM_OC_CYC
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // mode
  input wire clr,
  input wire run,
  // command
  input wire cmd_on,
  input wire cmd_wr,
  // fault sensors
  input wire oc_det,
  input wire lot_det,
  input wire ol_det,
  // results
  output reg drv_on_reg,
  output reg latch_reg,
  output reg [1:0] status_reg
);
  wire oc_long;
  wire trip;
  reg latch_next;
  reg [1:0] status_next;

  ldm_tmr #(.TERM(OC_CYC)) u_oc (
    .pclk(pclk),
    .presetn(presetn),
    .run(oc_det && drv_on_reg),
    .done(oc_long)
  );

  assign trip = drv_on_reg && (oc_long || lot_det);

  always @*
  begin
    latch_next = latch_reg;
    if (clr)
      latch_next = 1'b0;
    else
    begin
      if (cmd_wr && !cmd_on)
        latch_next = 1'b0;
      if (trip)
        latch_next = 1'b1;
    end
    // a latched driver reads 11 even while shut down globally
    if (latch_next)
      status_next = `LDM_ST_LATCH;
    else if (run && cmd_on)
      status_next = `LDM_ST_ON;
    else if (ol_det)
      status_next = `LDM_ST_OPEN;
    else
      status_next = `LDM_ST_OFF;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      latch_reg <= 1'b0;
      drv_on_reg <= 1'b0;
      status_reg <= `LDM_ST_OFF;
    end
    else
    begin
      latch_reg <= latch_next;
      drv_on_reg <= run && cmd_on && !latch_next && !clr;
      status_reg <= status_next;
    end
  end
endmodule

// file: logic/ldm_tmr.v
`timescale 1ns/10ps
`include "ldm_map.vh"
module ldm_tmr #(
  parameter [31:0] TERM = 32'h0000_0001
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire run,
  // result
  output wire done
);
  reg [31:0] cnt_reg;
  reg [31:0] cnt_next;

  // counter restarts whenever run drops
  always @*
  begin
    cnt_next = cnt_reg;
    if (!run)
      cnt_next = 32'h0000_0000;
    else if (cnt_reg != TERM)
      cnt_next = cnt_reg + 32'h0000_0001;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_reg <= 32'h0000_0000;
    else
      cnt_reg <= cnt_next;
  end

  assign done = run && (cnt_reg == TERM);
endmodule

// file: logic/ldm_top.v
`timescale 1ns/10ps
`include "ldm_map.vh"
module ldm_top #(
  parameter [31:0] INIT_CYC = `LDM_INIT_CYC,
  parameter [31:0] IDLE_CYC = `LDM_IDLE_CYC,
  parameter [31:0] WAKE_CYC = `LDM_WAKE_CYC
) (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // supply and temperature comparators
  input wire supply_por_ok,
  input wire supply_uv_low,
  input wire supply_uv_high,
  input wire gtsd_hot,
  input wire gtsd_cool,
  // configuration reader
  input wire cfg_ready,
  input wire cfg_valid,
  // lin transceiver
  input wire lin_rx,
  output wire lin_trx_en,
  output wire lin_pullup_en,
  output wire lin_wake_en,
  // protocol error reports
  input wire perr_stb,
  input wire [2:0] perr_code,
  // drivers
  input wire [7:0] oc_det,
  input wire [1:0] lot_det,
  input wire [1:0] ol_det,
  output wire [7:0] driver_output,
  output wire driver_hiz,
  output wire [2:0] mode
);

  // ****************************************
  // apb decode
  // ****************************************
  function known;
    input [7:0] a;
    begin
      known = (a == `LDM_OFS_CTRL) || (a == `LDM_OFS_STAT) ||
              (a == `LDM_OFS_CHST) || (a == `LDM_OFS_RESP) ||
              (a == `LDM_OFS_RESP_HI);
    end
  endfunction

  wire setup;
  wire acc_wr;
  wire acc_rd;
  wire ctrl_wr;
  wire rsp_rd;

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign setup = psel && !penable;
  assign acc_wr = psel && penable && pwrite && known(paddr);
  assign acc_rd = psel && penable && !pwrite;
  assign ctrl_wr = acc_wr && (paddr == `LDM_OFS_CTRL);
  assign rsp_rd = acc_rd && (paddr == `LDM_OFS_RESP);

  // ****************************************
  // state
  // ****************************************
  reg [2:0] mode_reg;
  reg [2:0] mode_next;
  reg [7:0] cmd_reg;
  reg [7:0] cmd_next;
  reg [2:0] err_reg;
  reg [2:0] err_next;
  reg rx_reg;
  reg wake_arm_reg;
  reg cmd_wr;

  wire rx_fall;
  wire init_to;
  wire idle_to;
  wire wake_ok;
  wire go_sleep;
  wire tgt_rst;
  wire [7:0] latch;
  wire [15:0] chst;
  wire [4:0] app;
  wire [7:0] byte1;
  wire run;
  wire in_norm;
  wire in_sleep;

  assign in_norm = (mode_reg == `LDM_M_NORM);
  assign in_sleep = (mode_reg == `LDM_M_SLEEP);
  assign rx_fall = rx_reg && !lin_rx;
  assign go_sleep = ctrl_wr && pwdata[`LDM_CTRL_SLEEP_BIT] && in_norm;
  // the reset request reaches every device of the node alike
  assign tgt_rst = ctrl_wr && pwdata[`LDM_CTRL_TRST_BIT] &&
                   (in_norm || mode_reg == `LDM_M_GTSD);

  // ****************************************
  // timers
  // ****************************************
  ldm_tmr #(.TERM(INIT_CYC)) u_init (
    .pclk(pclk),
    .presetn(presetn),
    .run(mode_reg == `LDM_M_INIT),
    .done(init_to)
  );

  // idle counter also runs in undervoltage; any falling edge restarts it
  ldm_tmr #(.TERM(IDLE_CYC)) u_idle (
    .pclk(pclk),
    .presetn(presetn),
    .run((in_norm || mode_reg == `LDM_M_UV) && !rx_fall),
    .done(idle_to)
  );

  ldm_tmr #(.TERM(WAKE_CYC)) u_wake (
    .pclk(pclk),
    .presetn(presetn),
    .run(in_sleep && !lin_rx),
    .done(wake_ok)
  );

  // ****************************************
  // mode sequencer
  // ****************************************
  always @*
  begin
    mode_next = mode_reg;
    if (!supply_por_ok)
      mode_next = `LDM_M_POR;
    else
    begin
      case (mode_reg)
        `LDM_M_POR:
          mode_next = `LDM_M_INIT;
        `LDM_M_INIT:
        begin
          // a reader that never answers counts as a faulty strap
          if (cfg_ready)
            mode_next = cfg_valid ? `LDM_M_NORM : `LDM_M_SLEEP;
          else if (init_to)
            mode_next = `LDM_M_SLEEP;
        end
        `LDM_M_NORM:
        begin
          if (go_sleep || idle_to)
            mode_next = `LDM_M_SLEEP;
          else if (supply_uv_low)
            mode_next = `LDM_M_UV;
          else if (gtsd_hot)
            mode_next = `LDM_M_GTSD;
        end
        `LDM_M_UV:
        begin
          if (idle_to)
            mode_next = `LDM_M_SLEEP;
          else if (supply_uv_high)
            mode_next = `LDM_M_NORM;
        end
        `LDM_M_GTSD:
        begin
          if (gtsd_cool)
            mode_next = `LDM_M_NORM;
        end
        `LDM_M_SLEEP:
        begin
          if (wake_arm_reg && lin_rx)
            mode_next = `LDM_M_INIT;
        end
        default:
          mode_next = `LDM_M_POR;
      endcase
    end
  end

  // ****************************************
  // output command and error field
  // ****************************************
  always @*
  begin
    cmd_next = cmd_reg;
    cmd_wr = 1'b0;
    if (mode_reg == `LDM_M_POR)
      cmd_next = `LDM_CMD_RST;
    else if (tgt_rst || go_sleep || mode_next == `LDM_M_SLEEP)
    begin
      cmd_next = `LDM_CMD_RST;
      cmd_wr = 1'b1;
    end
    else if (ctrl_wr)
    begin
      // one write sets all eight outputs together
      cmd_next = pwdata[7:0];
      cmd_wr = 1'b1;
    end
  end

  // sleep leaves the field alone; only power-up and a targeted reset reload it
  always @*
  begin
    err_next = err_reg;
    if (mode_reg == `LDM_M_POR && mode_next == `LDM_M_INIT)
      err_next = `LDM_ERR_RST;
    else
    begin
      if (rsp_rd)
        err_next = `LDM_ERR_NONE;
      if (tgt_rst)
        err_next = `LDM_ERR_RST;
      // a report in the clearing cycle survives the clear
      if (perr_stb && perr_code > err_next)
        err_next = perr_code;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg <= `LDM_M_POR;
      cmd_reg <= `LDM_CMD_RST;
      err_reg <= `LDM_ERR_NONE;
      rx_reg <= 1'b1;
      wake_arm_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      cmd_reg <= cmd_next;
      err_reg <= err_next;
      rx_reg <= lin_rx;
      if (!in_sleep)
        wake_arm_reg <= 1'b0;
      else if (wake_ok)
        wake_arm_reg <= 1'b1;
    end
  end

  // ****************************************
  // channels
  // ****************************************
  // undervoltage keeps drivers as they were; outside normal and undervoltage they stop
  assign run = in_norm || (mode_reg == `LDM_M_UV);

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_ch
      wire lot;
      wire ol;
      if (gi == 3 || gi == 7)
      begin : g_hot
        assign lot = lot_det[gi / 4];
        assign ol = ol_det[gi / 4];
      end
      else
      begin : g_plain
        assign lot = 1'b0;
        assign ol = 1'b0;
      end
      ldm_chan u_ch (
        .pclk(pclk),
        .presetn(presetn),
        .clr(mode_reg == `LDM_M_POR),
        .run(run),
        .cmd_on(cmd_next[gi]),
        .cmd_wr(cmd_wr),
        .oc_det(oc_det[gi]),
        .lot_det(lot),
        .ol_det(ol),
        .drv_on_reg(driver_output[gi]),
        .latch_reg(latch[gi]),
        .status_reg(chst[2 * gi + 1:2 * gi])
      );
    end
  endgenerate

  // ****************************************
  // status fields
  // ****************************************
  // faults of channels 1-3 and 5-7 never reach the field
  assign app[4] = 1'b0;
  assign app[3] = (latch[3] | latch[7]) &
                  (mode_reg != `LDM_M_GTSD);
  assign app[2] = (mode_reg == `LDM_M_GTSD);
  assign app[1:0] = 2'b00;
  assign byte1 = {err_reg, app};

  // ****************************************
  // pins
  // ****************************************
  assign mode = mode_reg;
  assign driver_hiz = (mode_reg == `LDM_M_POR) ||
                      (mode_reg == `LDM_M_INIT);
  assign lin_trx_en = in_norm || (mode_reg == `LDM_M_GTSD);
  assign lin_pullup_en = driver_hiz;
  assign lin_wake_en = in_sleep;

  // ****************************************
  // apb read data
  // ****************************************
  // read data is captured in setup so the access cycle sees a flop
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pslverr <= !known(paddr);
      case (paddr)
        `LDM_OFS_CTRL:
          prdata <= {24'h00_0000, cmd_reg};
        `LDM_OFS_STAT:
          prdata <= {19'h0_0000, app, 1'b0, err_reg, 1'b0, mode_reg};
        `LDM_OFS_CHST:
          prdata <= {16'h0000, chst};
        `LDM_OFS_RESP:
          prdata <= {8'h00, chst[15:8], chst[7:0], byte1};
        `LDM_OFS_RESP_HI:
          prdata <= 32'h0000_0000;
        default:
          prdata <= 32'h0000_0000;
      endcase
    end
    else if (!psel)
      pslverr <= 1'b0;
  end
endmodule

// file: verification/ldm_lin_master.sv
`timescale 1ns/10ps
module ldm_lin_master (
  // clock
  input wire pclk,
  // traffic control
  input wire act,
  input wire wake,
  // bus level, 1 recessive
  output logic lin_rx
);
  // ****************************************
  // bus traffic
  // ****************************************
  int slot = 0;
  initial lin_rx = 1'b1;
  // three dominant cycles every 40 stand in for frames: too short to wake
  always @(posedge pclk)
  begin
    slot <= (slot + 1) % 40;
    if (wake)
      lin_rx <= 1'b0;
    else if (act)
      lin_rx <= (slot >= 3);
    else
      lin_rx <= 1'b1;
  end
endmodule

// file: verification/ldm_top_sva.sv
`timescale 1ns/10ps
`include "ldm_map.vh"
module ldm_top_sva #(
  parameter [31:0] INIT_CYC = 32'h14,
  parameter [31:0] IDLE_CYC = 32'hC8,
  parameter [31:0] WAKE_CYC = 32'hA
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // environment
  input wire supply_por_ok,
  input wire gtsd_cool,
  input wire cfg_ready,
  input wire cfg_valid,
  input wire lin_rx,
  // observed outputs
  input wire lin_trx_en,
  input wire lin_pullup_en,
  input wire lin_wake_en,
  input wire [7:0] driver_output,
  input wire driver_hiz,
  input wire [2:0] mode
);
  // ****************************************
  // helper counters
  // ****************************************
  reg [31:0] init_cnt;
  reg [31:0] idle_cnt;
  reg [31:0] dom_cnt;
  reg rx_q;
  // a recessive-to-dominant edge, or any mode but normal and undervoltage, restarts the idle count
  wire timed = (mode == `LDM_M_NORM) || (mode == `LDM_M_UV);
  wire fall = rx_q & ~lin_rx;

  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      init_cnt <= 32'h0;
      idle_cnt <= 32'h0;
      dom_cnt <= 32'h0;
      rx_q <= 1'b1;
    end
    else
    begin
      rx_q <= lin_rx;
      init_cnt <= (mode == `LDM_M_INIT) ? init_cnt + 32'h1 : 32'h0;
      idle_cnt <= (timed && !fall) ? idle_cnt + 32'h1 : 32'h0;
      // saturates so a stuck dominant bus cannot wrap the count
      dom_cnt <= lin_rx ? 32'h0 : dom_cnt + {31'h0, dom_cnt < 32'hFFFF};
    end
  end

  a_por_holds: assert property (
    !supply_por_ok |=> mode == `LDM_M_POR && driver_hiz && lin_pullup_en)
    else $error("reset state not held");
  // sampled presetn skips the edge that releases reset
  a_init_entry: assert property (
    presetn && mode == `LDM_M_POR && supply_por_ok |=>
    mode == `LDM_M_INIT)
    else $error("init not entered");
  a_init_exit: assert property (
    mode == `LDM_M_INIT && cfg_ready && supply_por_ok |=>
    mode == (cfg_valid ? `LDM_M_NORM : `LDM_M_SLEEP))
    else $error("wrong init exit");
  a_init_bound: assert property (
    init_cnt <= INIT_CYC + 32'h2 &&
    (mode != `LDM_M_INIT || (driver_hiz && !lin_trx_en)))
    else $error("init too long or not quiet");
  a_idle_bound: assert property (
    idle_cnt <= IDLE_CYC + 32'h3)
    else $error("idle timeout missed");
  a_sleep_off: assert property (
    (mode == `LDM_M_SLEEP) [*2] |-> driver_output == 8'h00 && lin_wake_en)
    else $error("sleep drivers on");
  a_wake_init: assert property (
    mode == `LDM_M_SLEEP && supply_por_ok && lin_rx &&
    dom_cnt > WAKE_CYC + 32'h1 |=> mode == `LDM_M_INIT)
    else $error("wake not taken");
  a_trx_modes: assert property (
    lin_trx_en == (mode == `LDM_M_NORM || mode == `LDM_M_GTSD))
    else $error("transceiver enable wrong");
  a_gtsd_off: assert property (
    (mode == `LDM_M_GTSD) [*2] |-> driver_output == 8'h00)
    else $error("shutdown drivers on");
  a_gtsd_exit: assert property (
    mode == `LDM_M_GTSD && gtsd_cool && supply_por_ok |=>
    mode == `LDM_M_NORM)
    else $error("shutdown not left");
endmodule

bind ldm_top ldm_top_sva #(
  .INIT_CYC(INIT_CYC),
  .IDLE_CYC(IDLE_CYC),
  .WAKE_CYC(WAKE_CYC)
) u_sva (
  .pclk, .presetn, .supply_por_ok, .gtsd_cool, .cfg_ready, .cfg_valid,
  .lin_rx, .lin_trx_en, .lin_pullup_en, .lin_wake_en, .driver_output,
  .driver_hiz, .mode
);

// file: verification/lin_driver_mode_fault_status_tb.sv
`timescale 1ns/10ps
`include "ldm_map.vh"
module lin_driver_mode_fault_status_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, perr_stb = 1'b0, act = 1'b1, wake = 1'b0;
  logic supply_por_ok = 1'b1, supply_uv_low = 1'b0, supply_uv_high = 1'b1;
  logic gtsd_hot = 1'b0, gtsd_cool = 1'b1, cfg_ready = 1'b0, cfg_valid = 1'b1;
  logic pready, pslverr, lin_rx, lin_trx_en, lin_pullup_en, lin_wake_en;
  logic driver_hiz, er;
  logic [7:0] paddr = 8'h00, oc_det = 8'h00, driver_output, cmd, lat = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic [1:0] lot_det = 2'h0, ol_det = 2'h0;
  logic [2:0] perr_code = 3'h0, mode, e_err = 3'h1;
  int n_errors = 0;
  int checks_done = 0;

  ldm_top #(.INIT_CYC(32'h14), .IDLE_CYC(32'hC8), .WAKE_CYC(32'hA)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .supply_por_ok, .supply_uv_low, .supply_uv_high,
    .gtsd_hot, .gtsd_cool, .cfg_ready, .cfg_valid, .lin_rx, .lin_trx_en,
    .lin_pullup_en, .lin_wake_en, .perr_stb, .perr_code, .oc_det, .lot_det,
    .ol_det, .driver_output, .driver_hiz, .mode);
  ldm_lin_master far_end (.pclk, .act, .wake, .lin_rx);

  initial
    forever
      #5 pclk = ~pclk;

  // ****************************************
  // helpers
  // ****************************************
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // request stays put until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    rd_q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      n_errors++;
      complete_run();
    end
    @(posedge pclk);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("read data", rd_q, exp);
  endtask

  task stat(input logic [4:0] app, input logic [2:0] m);
    rd(`LDM_OFS_STAT, {19'h0, app, 1'b0, e_err, 1'b0, m});
  endtask

  task outs(input logic [7:0] exp);
    chk("driver", {24'h0, driver_output}, {24'h0, exp});
  endtask

  task chst(input logic [7:0] c, input logic [7:0] l);
    logic [15:0] e;
    for (int i = 0; i < 8; i++)
      e[2*i +: 2] = l[i] ? `LDM_ST_LATCH : (c[i] ? `LDM_ST_ON : `LDM_ST_OFF);
    rd(`LDM_OFS_CHST, {16'h0, e});
  endtask

  task wmode(input logic [2:0] m, input int lim);
    int n;
    n = 0;
    while (mode !== m && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    chk("mode", {29'h0, mode}, {29'h0, m});
    if (mode !== m)
      complete_run();
  endtask

  task perr(input logic [2:0] c);
    perr_stb <= 1'b1;
    perr_code <= c;
    @(posedge pclk);
    perr_stb <= 1'b0;
    e_err = (c > e_err) ? c : e_err;
    @(posedge pclk);
  endtask

  task pulse(input int n);
    wake <= 1'b1;
    cyc(n);
    wake <= 1'b0;
    cyc(2);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    void'($urandom(32'h5FF5));
    cyc(6);
    presetn <= 1'b1;
    wmode(`LDM_M_INIT, 3);
    chk("quiet init", {driver_hiz, lin_trx_en}, 32'h2);
    cfg_ready <= 1'b1;
    wmode(`LDM_M_NORM, 5);
    stat(5'h00, `LDM_M_NORM);
    rd(`LDM_OFS_RESP, 32'h0055_5520);
    e_err = 3'h0;
    stat(5'h00, `LDM_M_NORM);
    $display("power-up test ended");
    cmd = 8'($urandom) | 8'h81;
    apb(1'b1, `LDM_OFS_CTRL, {24'h0, cmd});
    cyc(2);
    outs(cmd);
    chst(cmd, lat);
    oc_det <= 8'h01;
    cyc(1600);
    oc_det <= 8'h00;
    lat = 8'h01;
    outs(cmd & ~lat);
    stat(5'h00, `LDM_M_NORM);
    lot_det <= 2'h2;
    cyc(2);
    lot_det <= 2'h0;
    lat = 8'h81;
    outs(cmd & ~lat);
    chst(cmd, lat);
    stat(5'h08, `LDM_M_NORM);
    gtsd_hot <= 1'b1;
    gtsd_cool <= 1'b0;
    wmode(`LDM_M_GTSD, 5);
    cyc(2);
    outs(8'h00);
    stat(5'h04, `LDM_M_GTSD);
    gtsd_hot <= 1'b0;
    gtsd_cool <= 1'b1;
    wmode(`LDM_M_NORM, 5);
    stat(5'h08, `LDM_M_NORM);
    cmd = cmd & 8'h7E;
    apb(1'b1, `LDM_OFS_CTRL, {24'h0, cmd});
    chst(cmd, 8'h00);
    stat(5'h00, `LDM_M_NORM);
    $display("fault test ended");
    supply_uv_low <= 1'b1;
    supply_uv_high <= 1'b0;
    wmode(`LDM_M_UV, 5);
    cyc(2);
    outs(cmd);
    supply_uv_low <= 1'b0;
    supply_uv_high <= 1'b1;
    wmode(`LDM_M_NORM, 5);
    apb(1'b1, `LDM_OFS_CTRL, 32'h0000_0200);
    e_err = 3'h1;
    outs(8'h00);
    stat(5'h00, `LDM_M_NORM);
    ol_det <= 2'h1;
    cyc(1);
    rd(`LDM_OFS_CHST, 32'h0000_5515);
    ol_det <= 2'h0;
    for (int c = 1; c < 8; c++)
    begin
      perr(3'(c));
      stat(5'h00, `LDM_M_NORM);
    end
    perr(3'h4);
    stat(5'h00, `LDM_M_NORM);
    rd(`LDM_OFS_RESP, 32'h0055_55E0);
    e_err = 3'h0;
    rd(`LDM_OFS_RESP_HI, 32'h0);
    stat(5'h00, `LDM_M_NORM);
    rd(8'h14, 32'h0);
    chk("slave error", {31'h0, er}, 32'h1);
    $display("status test ended");
    perr(3'h6);
    apb(1'b1, `LDM_OFS_CTRL, 32'h0000_01FF);
    wmode(`LDM_M_SLEEP, 5);
    cyc(2);
    outs(8'h00);
    stat(5'h00, `LDM_M_SLEEP);
    pulse(5);
    cyc(5);
    wmode(`LDM_M_SLEEP, 1);
    cfg_ready <= 1'b0;
    pulse(14);
    wmode(`LDM_M_INIT, 5);
    cfg_valid <= 1'b0;
    cfg_ready <= 1'b1;
    wmode(`LDM_M_SLEEP, 5);
    cfg_ready <= 1'b0;
    cfg_valid <= 1'b1;
    pulse(14);
    wmode(`LDM_M_INIT, 5);
    cfg_ready <= 1'b1;
    wmode(`LDM_M_NORM, 5);
    act <= 1'b0;
    cyc(150);
    wmode(`LDM_M_NORM, 1);
    wmode(`LDM_M_SLEEP, 100);
    $display("sleep test ended");
    supply_por_ok <= 1'b0;
    cyc(2);
    wmode(`LDM_M_POR, 1);
    chk("reset pins", {driver_hiz, lin_pullup_en}, 32'h3);
    cfg_ready <= 1'b0;
    supply_por_ok <= 1'b1;
    e_err = 3'h1;
    wmode(`LDM_M_INIT, 3);
    wmode(`LDM_M_SLEEP, 30);
    stat(5'h00, `LDM_M_SLEEP);
    $display("power loss test ended");
    complete_run();
  end
endmodule
